// >>> crcw_master_model.sv
`timescale 1ns/1ps
module crcw_master_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        wr_ready_i,
  output logic      [3:0]  addr_o,
  output logic      [31:0] wr_data_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o = 4'h0;
    wr_data_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One strobe per call; a data write waits for room so no word is dropped
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    // Ready read 1 ns after the edge that ended the last call covers every earlier push
    while (w && a == 4'h0 && wr_ready_i !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wr_data_o <= ~d;
    #1;
    q = rd_data_i;
  endtask

  // Data strobe held for n edges regardless of ready, to provoke refusals
  task automatic flood(input logic [31:0] d, input int n);
    @(posedge clk_i);
    addr_o <= 4'h0;
    wr_data_o <= d;
    wr_o <= 1'b1;
    rd_o <= 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      wr_data_o <= wr_data_o + 32'h1;
    end
    wr_o <= 1'b0;
    #1;
  endtask
endmodule // crcw_master_model

// >>> crcw_pkg.sv
package crcw_pkg;

  localparam logic [3:0]  CHECKSUM_DATA_OFFSET    = 4'h0;
  localparam logic [3:0]  SCRATCH_BYTE_OFFSET     = 4'h4;
  localparam logic [3:0]  CHECKSUM_CONTROL_OFFSET = 4'h8;
  localparam logic [3:0]  CHECKSUM_STATUS_OFFSET  = 4'hC;

  localparam logic [31:0] CRC_POLY                = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED                = 32'hFFFFFFFF;
  localparam logic [31:0] CHECKSUM_DATA_RESET     = 32'hFFFFFFFF;
  localparam logic [7:0]  SCRATCH_BYTE_RESET      = 8'h00;

  localparam int          RESTART_BIT             = 0;
  localparam int          STATUS_BUSY_BIT         = 0;
  localparam int          STATUS_OVERFLOW_BIT     = 1;
  localparam int          SCRATCH_WIDTH           = 8;

  localparam logic [1:0]  CRC_CYCLES              = 2'h3;
  localparam int          BUF_DEPTH               = 2;
  localparam logic [1:0]  BUF_FULL_COUNT          = 2'h2;

endpackage : crcw_pkg

// >>> crcw_top.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
module crcw_top
  import crcw_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rd_data_o,
  output logic             wr_ready_o
);

  logic [31:0] crc_reg;
  logic [7:0]  scratch_reg;
  logic        restart_reg;
  logic        overflow_reg;
  logic [31:0] buf_reg [BUF_DEPTH];
  logic        buf_wr_ptr_reg;
  logic        buf_rd_ptr_reg;
  logic [1:0]  buf_count_reg;
  logic [1:0]  buf_count_next;
  logic        eng_busy_reg;
  logic [1:0]  eng_cnt_reg;
  logic [31:0] eng_word_reg;
  logic [31:0] rd_data_reg;
  logic        wr_ready_reg;

  logic        data_wr;
  logic        push;
  logic        pop;
  logic        eng_done;
  logic        buf_wr_idx;

  // Bit-serial MSB-first division unrolled over the whole word
  function automatic logic [31:0] crc_fn(input logic [31:0] crc, input logic [31:0] word);
    logic [31:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ word[i];
      c  = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  assign data_wr    = wr_i && (addr_i == CHECKSUM_DATA_OFFSET);
  // The master sees ready straight from a flop, so a full buffer refuses the word
  assign push       = data_wr && (buf_count_reg != BUF_FULL_COUNT);
  assign pop        = !restart_reg && !eng_busy_reg && (buf_count_reg != 2'h0);
  assign eng_done   = eng_busy_reg && (eng_cnt_reg == 2'h1) && !restart_reg;
  assign buf_wr_idx = restart_reg ? 1'b0 : buf_wr_ptr_reg;

  always_comb begin
    if (restart_reg) begin
      buf_count_next = push ? 2'h1 : 2'h0;
    end else begin
      buf_count_next = buf_count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Two-entry word buffer between bus and engine
  for (genvar g = 0; g < BUF_DEPTH; g++) begin : g_buf
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        buf_reg[g] <= 32'h00000000;
      end else if (push && (buf_wr_idx == 1'(g))) begin
        buf_reg[g] <= wr_data_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_count_reg  <= 2'h0;
      wr_ready_reg   <= 1'b0;
    end else begin
      buf_wr_ptr_reg <= push ? ~buf_wr_idx : buf_wr_idx;
      buf_rd_ptr_reg <= restart_reg ? 1'b0 : (buf_rd_ptr_reg ^ pop);
      buf_count_reg  <= buf_count_next;
      wr_ready_reg   <= (buf_count_next != BUF_FULL_COUNT);
    end
  end

  // Engine holds a word for the full computation time before committing
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eng_busy_reg <= 1'b0;
      eng_cnt_reg  <= 2'h0;
      eng_word_reg <= 32'h00000000;
    end else if (restart_reg) begin
      eng_busy_reg <= 1'b0;
      eng_cnt_reg  <= 2'h0;
    end else if (pop) begin
      eng_busy_reg <= 1'b1;
      eng_cnt_reg  <= CRC_CYCLES - 2'h1;
      eng_word_reg <= buf_reg[buf_rd_ptr_reg];
    end else if (eng_busy_reg) begin
      eng_cnt_reg  <= eng_cnt_reg - 2'h1;
      eng_busy_reg <= !eng_done;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc_reg <= CHECKSUM_DATA_RESET;
    end else if (restart_reg) begin
      crc_reg <= CRC_SEED;
    end else if (eng_done) begin
      crc_reg <= crc_fn(crc_reg, eng_word_reg);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      restart_reg <= 1'b0;
    end else if (wr_i && (addr_i == CHECKSUM_CONTROL_OFFSET) && wr_data_i[RESTART_BIT]) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= 1'b0;
    end
  end

  // Restart never touches the scratch byte
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scratch_reg <= SCRATCH_BYTE_RESET;
    end else if (wr_i && (addr_i == SCRATCH_BYTE_OFFSET)) begin
      scratch_reg <= wr_data_i[SCRATCH_WIDTH-1:0];
    end
  end

  // A refused word is flagged; a new refusal wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_reg <= 1'b0;
    end else if (data_wr && !push) begin
      overflow_reg <= 1'b1;
    end else if (wr_i && (addr_i == CHECKSUM_STATUS_OFFSET) && wr_data_i[STATUS_OVERFLOW_BIT]) begin
      overflow_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_reg <= 32'h00000000;
    end else if (rd_i) begin
      unique case (addr_i)
        CHECKSUM_DATA_OFFSET:    rd_data_reg <= crc_reg;
        SCRATCH_BYTE_OFFSET:     rd_data_reg <= {24'h000000, scratch_reg};
        CHECKSUM_CONTROL_OFFSET: rd_data_reg <= {31'h00000000, restart_reg};
        CHECKSUM_STATUS_OFFSET:  rd_data_reg <= {30'h00000000, overflow_reg,
                                                 eng_busy_reg || (buf_count_reg != 2'h0)};
        default:                 rd_data_reg <= 32'h00000000;
      endcase
    end else begin
      rd_data_reg <= 32'h00000000;
    end
  end

  assign rd_data_o  = rd_data_reg;
  assign wr_ready_o = wr_ready_reg;

  property p_commit_value;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      eng_done |=> crc_reg == crc_fn($past(crc_reg), $past(eng_word_reg));
  endproperty
  a_commit_value: assert property (p_commit_value) else $error("checksum update wrong");

  property p_latency;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (push && buf_count_reg == 2'h0 && !eng_busy_reg && !restart_reg)
        ##1 !restart_reg [*3] |-> eng_done;
  endproperty
  a_latency: assert property (p_latency) else $error("word not done in four cycles");

  property p_word_pops;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      pop |=> eng_busy_reg && eng_word_reg == $past(buf_reg[buf_rd_ptr_reg]);
  endproperty
  a_word_pops: assert property (p_word_pops) else $error("buffered word not taken");

  property p_read_data;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == CHECKSUM_DATA_OFFSET |=> rd_data_o == $past(crc_reg);
  endproperty
  a_read_data: assert property (p_read_data) else $error("data read not last result");

  property p_refuse;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      data_wr && !wr_ready_o |=> overflow_reg && ($stable(buf_count_reg) || $past(pop) || $past(restart_reg));
  endproperty
  a_refuse: assert property (p_refuse) else $error("write while full not refused");

  property p_restart_seed;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      wr_i && addr_i == CHECKSUM_CONTROL_OFFSET && wr_data_i[RESTART_BIT] |-> ##2 crc_reg == CRC_SEED;
  endproperty
  a_restart_seed: assert property (p_restart_seed) else $error("restart did not seed");

  property p_restart_clear;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      restart_reg && !(wr_i && addr_i == CHECKSUM_CONTROL_OFFSET && wr_data_i[RESTART_BIT]) |=> !restart_reg;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart bit stuck");

  property p_scratch_write;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      wr_i && addr_i == SCRATCH_BYTE_OFFSET |=> scratch_reg == $past(wr_data_i[SCRATCH_WIDTH-1:0]);
  endproperty
  a_scratch_write: assert property (p_scratch_write) else $error("scratch byte not stored");

  property p_scratch_keep;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      restart_reg && !(wr_i && addr_i == SCRATCH_BYTE_OFFSET) |=> $stable(scratch_reg);
  endproperty
  a_scratch_keep: assert property (p_scratch_keep) else $error("restart changed scratch");

  property p_scratch_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !(wr_i && addr_i == SCRATCH_BYTE_OFFSET) |=> $stable(scratch_reg);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed without write");

  property p_scratch_read;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == SCRATCH_BYTE_OFFSET |=> rd_data_o == {24'h000000, $past(scratch_reg)};
  endproperty
  a_scratch_read: assert property (p_scratch_read) else $error("scratch read wrong");

  property p_control_read;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == CHECKSUM_CONTROL_OFFSET |=> rd_data_o == {31'h00000000, $past(restart_reg)};
  endproperty
  a_control_read: assert property (p_control_read) else $error("control read wrong");

  // A restart empties buffer and engine; only a word written in that cycle survives
  property p_restart_flush;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      restart_reg |=> !eng_busy_reg && buf_count_reg == {1'b0, $past(push)};
  endproperty
  a_restart_flush: assert property (p_restart_flush) else $error("restart did not flush");

  property p_crc_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !eng_done && !restart_reg |=> $stable(crc_reg);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("checksum moved without commit");

  property p_read_idle;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !rd_i |=> rd_data_o == 32'h00000000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not zero when idle");

  property p_overflow_clear;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      wr_i && addr_i == CHECKSUM_STATUS_OFFSET && wr_data_i[STATUS_OVERFLOW_BIT] |=> !overflow_reg;
  endproperty
  a_overflow_clear: assert property (p_overflow_clear) else $error("overflow not cleared");

  property p_overflow_sticky;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      overflow_reg && !(wr_i && addr_i == CHECKSUM_STATUS_OFFSET && wr_data_i[STATUS_OVERFLOW_BIT]) |=> overflow_reg;
  endproperty
  a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow lost");

  property p_count_bound;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      buf_count_reg <= BUF_FULL_COUNT;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("buffer count beyond depth");

  property p_engine_takes;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !restart_reg && !eng_busy_reg && buf_count_reg != 2'h0 |=> eng_busy_reg;
  endproperty
  a_engine_takes: assert property (p_engine_takes) else $error("waiting word not taken");

  property p_busy_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      eng_busy_reg && !eng_done && !restart_reg |=> eng_busy_reg;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("engine dropped a word");

endmodule // crcw_top

// >>> crcw_top_test.sv
`timescale 1ns/1ps
module crcw_top_test;
  import crcw_pkg::*;
  logic        clk      = 1'b0;
  logic        rst_b    = 1'b0;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        wr_ready;
  logic        saw_full = 1'b0;
  logic [31:0] seed     = 32'h00000050;
  logic [31:0] q;
  logic [31:0] w;
  logic [31:0] crc;
  int          n_errors = 0;
  int          tests_run = 0;

  always #2 clk = ~clk;
  always @(negedge clk) if (rst_b && wr_ready === 1'b0) saw_full <= 1'b1;

  crcw_top crcw_top_i (.core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wr_data_i(wdata),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .wr_ready_o(wr_ready));
  crcw_master_model crcw_master_model_i (.clk_i(clk), .rd_data_i(rdata), .wr_ready_i(wr_ready),
    .addr_o(addr), .wr_data_o(wdata), .wr_o(wr), .rd_o(rd));

  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Raw shift-register state, MSB first, no reflection or final inversion
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C11DB7 : 32'h0);
    return c;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    crcw_master_model_i.bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    crcw_master_model_i.bus(1'b1, a, d, q);
  endtask

  // Polls status until buffer and engine are empty; q keeps the last status
  task automatic idle();
    q = 32'h1;
    for (int n = 0; n < 60 && q[STATUS_BUSY_BIT] !== 1'b0; n++) begin
      crcw_master_model_i.bus(1'b0, CHECKSUM_STATUS_OFFSET, 32'h0, q);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(8000 * 4);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(CHECKSUM_DATA_OFFSET, 32'hFFFFFFFF, "data at reset");
    rdc(SCRATCH_BYTE_OFFSET, 32'h0, "scratch at reset");
    rdc(CHECKSUM_CONTROL_OFFSET, 32'h0, "control at reset");
    $display("test reset_values done");
    w = nxt();
    wrr(CHECKSUM_DATA_OFFSET, w);
    rdc(CHECKSUM_DATA_OFFSET, 32'hFFFFFFFF, "data before commit");
    @(posedge clk);
    rdc(CHECKSUM_DATA_OFFSET, fold(32'hFFFFFFFF, w), "data four clocks on");
    $display("test single_word done");
    w = nxt();
    wrr(SCRATCH_BYTE_OFFSET, w);
    rdc(SCRATCH_BYTE_OFFSET, {24'h0, w[7:0]}, "scratch");
    wrr(CHECKSUM_CONTROL_OFFSET, 32'h1);
    rdc(CHECKSUM_CONTROL_OFFSET, 32'h0, "control self clear");
    wrr(4'h2, nxt());
    rdc(CHECKSUM_DATA_OFFSET, 32'hFFFFFFFF, "data after restart");
    rdc(SCRATCH_BYTE_OFFSET, {24'h0, w[7:0]}, "scratch after restart");
    rdc(4'h2, 32'h0, "unmapped");
    $display("test scratch_restart done");
    for (int s = 0; s < 3; s++) begin
      wrr(CHECKSUM_CONTROL_OFFSET, 32'h1);
      crc = 32'hFFFFFFFF;
      saw_full <= 1'b0;
      for (int k = 0; k < 12; k++) begin
        w = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFFFFFF : nxt();
        wrr(CHECKSUM_DATA_OFFSET, w);
        crc = fold(crc, w);
      end
      idle();
      chk("stream status", 32'h0, q);
      chk("buffer stalled", 32'h1, {31'h0, saw_full});
      rdc(CHECKSUM_DATA_OFFSET, crc, "stream checksum");
      $display("test stream %0d done", s);
    end
    crcw_master_model_i.flood(nxt(), 6);
    idle();
    chk("overflow flagged", 32'h2, q);
    wrr(CHECKSUM_STATUS_OFFSET, 32'h2);
    rdc(CHECKSUM_STATUS_OFFSET, 32'h0, "overflow cleared");
    crcw_master_model_i.flood(nxt(), 6);
    $display("test overflow done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(SCRATCH_BYTE_OFFSET, 32'h0, "scratch after reset");
    rdc(CHECKSUM_DATA_OFFSET, 32'hFFFFFFFF, "data after reset");
    rdc(CHECKSUM_STATUS_OFFSET, 32'h0, "status after reset");
    $display("test second_reset done");
    final_report();
  end
endmodule // crcw_top_test
